// file: rtl/emc_control_bank.sv
module emc_control_bank
	import emc_pkg::*;
#(
	parameter logic [31:0] ID_VERSION  = 32'h00010000, // arbitrary value
	parameter int          SLOT_CYC    = EMC_SLOT_CYC,
	parameter int          LINK_TO_CYC = EMC_LINK_TIMEOUT_CYC
) (
	input  wire logic           clk_in,
	input  wire logic           reset_in,
	input  wire logic [11:0]    s_axi_awaddr_in,
	input  wire logic           s_axi_awvalid_in,
	output logic                s_axi_awready_out,
	input  wire logic [31:0]    s_axi_wdata_in,
	input  wire logic [3:0]     s_axi_wstrb_in,
	input  wire logic           s_axi_wvalid_in,
	output logic                s_axi_wready_out,
	output logic [1:0]          s_axi_bresp_out,
	output logic                s_axi_bvalid_out,
	input  wire logic           s_axi_bready_in,
	input  wire logic [11:0]    s_axi_araddr_in,
	input  wire logic           s_axi_arvalid_in,
	output logic                s_axi_arready_out,
	output logic [31:0]         s_axi_rdata_out,
	output logic [1:0]          s_axi_rresp_out,
	output logic                s_axi_rvalid_out,
	input  wire logic           s_axi_rready_in,
	input  wire logic           full_duplex_in,
	input  wire logic           gig_in,
	input  wire logic           short_gap_in,
	input  wire logic           transmit_clock_input_in,
	input  wire emc_rx_frame_t  rx_frame_in,
	input  wire logic           rx_busy_in,
	input  wire logic           tx_busy_in,
	input  wire logic           rx_flow_trigger_in,
	output emc_rx_result_t      rx_result_out,
	output logic                gig_out,
	output logic                full_duplex_out,
	output logic                full_duplex_mode_out,
	output logic                gig_mode_out,
	output logic                ten_gigabit_mode_out,
	output logic                interface_output_a_out,
	output logic                interface_output_b_out,
	output logic                gig_path_reset_out,
	output logic                ten_gig_path_reset_out,
	output logic                crc_castagnoli_out,
	output logic                short_gap_tx_out,
	output logic                transmit_pacing_enable_out,
	output logic                tx_hold_out,
	output logic                send_pause_out,
	output logic                force_collision_out,
	output logic                mac_reset_out,
	output logic [13:0]         rx_max_len_out,
	output logic [15:0]         tx_gap_out
);

	// ==========================================================
	// register state
	logic [31:0] ctl_q;
	logic [13:0] maxlen_q;
	logic [15:0] txgap_q;
	logic [1:0]  emul_q;
	logic        srst_q;
	logic        idle_q;
	logic [15:0] rx_pause_q;
	logic [15:0] tx_pause_q;

	// ==========================================================
	// pin synchronisers, sample then use
	logic [1:0] fd_s_q;
	logic [1:0] gig_s_q;
	logic [1:0] sg_s_q;
	logic [1:0] tck_s_q;
	logic       tck_prev_q;

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			fd_s_q     <= 2'h0;
			gig_s_q    <= 2'h0;
			sg_s_q     <= 2'h0;
			tck_s_q    <= 2'h0;
			tck_prev_q <= 1'b0;
		end else begin
			fd_s_q     <= {fd_s_q[0], full_duplex_in};
			gig_s_q    <= {gig_s_q[0], gig_in};
			sg_s_q     <= {sg_s_q[0], short_gap_in};
			tck_s_q    <= {tck_s_q[0], transmit_clock_input_in};
			tck_prev_q <= tck_s_q[1];
		end
	end

	// ==========================================================
	// transmit clock watchdog
	logic [7:0] tck_cnt_q;
	logic       tck_alive_q;

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			tck_cnt_q   <= 8'h00;
			tck_alive_q <= 1'b0;
		end else if (tck_s_q[1] != tck_prev_q) begin
			tck_cnt_q   <= 8'h00;
			tck_alive_q <= 1'b1;
		end else if (tck_cnt_q >= 8'(LINK_TO_CYC)) begin
			tck_alive_q <= 1'b0;
		end else begin
			tck_cnt_q <= tck_cnt_q + 8'h01;
		end
	end

	// ==========================================================
	// mode resolution
	logic gig_sel;
	logic fd_sel;
	logic gig_mode;
	logic fd_mode;

	always_comb begin
		gig_sel = ctl_q[EMC_CTL_EXT] ? gig_s_q[1] : ctl_q[EMC_CTL_GIG];
		fd_sel  = ctl_q[EMC_CTL_EXT] ? fd_s_q[1] : ctl_q[EMC_CTL_FD];
		gig_mode = gig_sel & (tck_alive_q | ctl_q[EMC_CTL_GIGF]);
		// loopback and gigabit force full duplex
		fd_mode = fd_sel | gig_mode | ctl_q[EMC_CTL_LOOP];
	end

	// ==========================================================
	// bus slave: write channel
	logic        aw_held_q;
	logic        w_held_q;
	logic [11:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        do_write;
	logic [31:0] wmerge;

	assign do_write = aw_held_q & w_held_q & ~s_axi_bvalid_out;

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			aw_held_q         <= 1'b0;
			w_held_q          <= 1'b0;
			awaddr_q          <= 12'h000;
			wdata_q           <= 32'h00000000;
			wstrb_q           <= 4'h0;
			s_axi_awready_out <= 1'b0;
			s_axi_wready_out  <= 1'b0;
			s_axi_bvalid_out  <= 1'b0;
			s_axi_bresp_out   <= EMC_RESP_OKAY;
		end else begin
			s_axi_awready_out <= ~aw_held_q & ~s_axi_awready_out & ~s_axi_bvalid_out;
			s_axi_wready_out  <= ~w_held_q & ~s_axi_wready_out & ~s_axi_bvalid_out;
			if (s_axi_awvalid_in & s_axi_awready_out) begin
				aw_held_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr_in;
			end
			if (s_axi_wvalid_in & s_axi_wready_out) begin
				w_held_q <= 1'b1;
				wdata_q  <= s_axi_wdata_in;
				wstrb_q  <= s_axi_wstrb_in;
			end
			if (do_write) begin
				aw_held_q        <= 1'b0;
				w_held_q         <= 1'b0;
				s_axi_bvalid_out <= 1'b1;
			end else if (s_axi_bready_in) begin
				s_axi_bvalid_out <= 1'b0;
			end
		end
	end

	// byte-lane merge against the addressed register's current value
	function automatic logic [31:0] merge(input logic [31:0] old_v,
	                                      input logic [31:0] new_v,
	                                      input logic [3:0]  strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return r;
	endfunction

	always_comb begin
		case (awaddr_q)
			EMC_ADDR_CONTROL: wmerge = merge(ctl_q, wdata_q, wstrb_q);
			EMC_ADDR_MAXLEN:  wmerge = merge({18'h0, maxlen_q}, wdata_q, wstrb_q);
			EMC_ADDR_EMUL:    wmerge = merge({30'h0, emul_q}, wdata_q, wstrb_q);
			EMC_ADDR_TXGAP:   wmerge = merge({16'h0, txgap_q}, wdata_q, wstrb_q);
			default:          wmerge = merge(32'h0, wdata_q, wstrb_q);
		endcase
	end

	// ==========================================================
	// writable registers
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			ctl_q    <= EMC_CTL_RESET;
			maxlen_q <= EMC_MAXLEN_RESET;
			txgap_q  <= EMC_TXGAP_RESET;
			emul_q   <= EMC_EMUL_RESET;
		end else if (do_write) begin
			case (awaddr_q)
				EMC_ADDR_CONTROL: ctl_q    <= wmerge & EMC_CTL_WMASK;
				EMC_ADDR_MAXLEN:  maxlen_q <= wmerge[13:0];
				EMC_ADDR_EMUL:    emul_q   <= wmerge[1:0];
				EMC_ADDR_TXGAP:   txgap_q  <= wmerge[15:0];
				default: ;
			endcase
		end
	end

	// soft reset: reads one until the mac logic has been reset
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			srst_q        <= 1'b0;
			mac_reset_out <= 1'b0;
		end else begin
			srst_q        <= do_write & (awaddr_q == EMC_ADDR_SRESET) & wmerge[0];
			mac_reset_out <= srst_q;
		end
	end

	// ==========================================================
	// bus slave: read channel
	logic [31:0] status_word;

	assign status_word = {idle_q, 26'h0, ctl_q[EMC_CTL_EXT] & gig_s_q[1],
	                      ctl_q[EMC_CTL_EXT] & fd_s_q[1], 1'b0,
	                      ctl_q[EMC_CTL_RXFL] & rx_flow_trigger_in,
	                      tx_pause_q != 16'h0000};

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out  <= 1'b0;
			s_axi_rdata_out   <= 32'h00000000;
			s_axi_rresp_out   <= EMC_RESP_OKAY;
		end else begin
			s_axi_arready_out <= ~s_axi_arready_out & ~s_axi_rvalid_out;
			if (s_axi_arvalid_in & s_axi_arready_out) begin
				s_axi_rvalid_out <= 1'b1;
				case (s_axi_araddr_in)
					EMC_ADDR_ID:      s_axi_rdata_out <= ID_VERSION;
					EMC_ADDR_CONTROL: s_axi_rdata_out <= ctl_q;
					EMC_ADDR_STATUS:  s_axi_rdata_out <= status_word;
					EMC_ADDR_SRESET:  s_axi_rdata_out <= {31'h0, srst_q | mac_reset_out};
					EMC_ADDR_MAXLEN:  s_axi_rdata_out <= {18'h0, maxlen_q};
					EMC_ADDR_RXPAUSE: s_axi_rdata_out <= {16'h0, rx_pause_q};
					EMC_ADDR_TXPAUSE: s_axi_rdata_out <= {16'h0, tx_pause_q};
					EMC_ADDR_EMUL:    s_axi_rdata_out <= {30'h0, emul_q};
					EMC_ADDR_TXGAP:   s_axi_rdata_out <= {16'h0, txgap_q};
					default:          s_axi_rdata_out <= 32'h00000000;
				endcase
			end else if (s_axi_rready_in) begin
				s_axi_rvalid_out <= 1'b0;
			end
		end
	end

	// ==========================================================
	// idle handshake
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			idle_q <= 1'b0;
		end else begin
			// idle only when commanded and both paths quiet
			idle_q <= ctl_q[EMC_CTL_IDLE] & ~rx_busy_in & ~tx_busy_in;
		end
	end

	// ==========================================================
	// receive frame filter
	logic any_err;

	assign any_err = rx_frame_in.crc_err | rx_frame_in.align_err | rx_frame_in.code_err;

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			rx_result_out <= '0;
		end else if (mac_reset_out) begin
			rx_result_out <= '0;
		end else begin
			rx_result_out.valid     <= rx_frame_in.valid;
			rx_result_out.crc_err   <= rx_frame_in.crc_err;
			rx_result_out.align_err <= rx_frame_in.align_err;
			rx_result_out.code_err  <= rx_frame_in.code_err;
			rx_result_out.control   <= rx_frame_in.control;
			rx_result_out.fragment   <= rx_frame_in.short_frame & any_err;
			rx_result_out.undersized <= rx_frame_in.short_frame & ~any_err;
			if (rx_frame_in.short_frame) begin
				// short frames copied only on request
				rx_result_out.deliver <= ctl_q[EMC_CTL_CSF];
			end else if (any_err) begin
				// errored frames copied only on request
				rx_result_out.deliver <= ctl_q[EMC_CTL_CEF];
			end else if (rx_frame_in.control) begin
				// control frames copied only on request
				rx_result_out.deliver <= ctl_q[EMC_CTL_CMF];
			end else begin
				rx_result_out.deliver <= 1'b1;
			end
		end
	end

	// ==========================================================
	// pause timers, decremented per slot time
	logic [7:0] slot_cnt_q;
	logic       slot_tick;
	logic       honour_pause;
	logic       rx_flow_act;

	assign slot_tick = (slot_cnt_q == 8'(SLOT_CYC - 1));
	// pause honoured in full duplex only
	assign honour_pause = rx_frame_in.valid & rx_frame_in.pause & ~any_err & fd_mode &
	                      ctl_q[EMC_CTL_TXFL];
	assign rx_flow_act = ctl_q[EMC_CTL_RXFL] & rx_flow_trigger_in;

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			slot_cnt_q <= 8'h00;
		end else begin
			slot_cnt_q <= slot_tick ? 8'h00 : slot_cnt_q + 8'h01;
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			tx_pause_q <= 16'h0000;
		end else if (mac_reset_out) begin
			tx_pause_q <= 16'h0000;
		end else if (honour_pause) begin
			tx_pause_q <= rx_frame_in.pause_quanta;
		end else if (slot_tick & (tx_pause_q != 16'h0000)) begin
			tx_pause_q <= tx_pause_q - 16'h0001;
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			rx_pause_q     <= 16'h0000;
			send_pause_out <= 1'b0;
		end else if (mac_reset_out) begin
			rx_pause_q     <= 16'h0000;
			send_pause_out <= 1'b0;
		end else begin
			// full duplex: pause frame each time the timer runs out
			send_pause_out <= rx_flow_act & fd_mode & (rx_pause_q == 16'h0000) &
			                  ~send_pause_out;
			if (send_pause_out) begin
				rx_pause_q <= EMC_PAUSE_RELOAD;
			end else if (slot_tick & (rx_pause_q != 16'h0000)) begin
				rx_pause_q <= rx_pause_q - 16'h0001;
			end
		end
	end

	// ==========================================================
	// mode and control outputs
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			gig_out                    <= 1'b0;
			full_duplex_out            <= 1'b0;
			full_duplex_mode_out       <= 1'b0;
			gig_mode_out               <= 1'b0;
			ten_gigabit_mode_out       <= 1'b0;
			interface_output_a_out     <= 1'b0;
			interface_output_b_out     <= 1'b0;
			gig_path_reset_out         <= 1'b1;
			ten_gig_path_reset_out     <= 1'b1;
			crc_castagnoli_out         <= 1'b0;
			short_gap_tx_out           <= 1'b0;
			transmit_pacing_enable_out <= 1'b0;
			tx_hold_out                <= 1'b0;
			force_collision_out        <= 1'b0;
			rx_max_len_out             <= EMC_MAXLEN_RESET;
			tx_gap_out                 <= EMC_TXGAP_RESET;
		end else begin
			gig_out              <= ctl_q[EMC_CTL_GIG];
			full_duplex_out      <= ctl_q[EMC_CTL_FD];
			full_duplex_mode_out <= fd_mode;
			gig_mode_out         <= gig_mode & ~ctl_q[EMC_CTL_TEN_GIGABIT_MODE];
			ten_gigabit_mode_out <= ctl_q[EMC_CTL_TEN_GIGABIT_MODE];
			interface_output_a_out <= ctl_q[EMC_CTL_IFA];
			interface_output_b_out <= ctl_q[EMC_CTL_IFB];
			// gigabit-class path reset, also on soft reset
			gig_path_reset_out     <= ~ctl_q[EMC_CTL_GEN] | srst_q;
			ten_gig_path_reset_out <= ~ctl_q[EMC_CTL_XGEN] | srst_q;
			crc_castagnoli_out     <= ctl_q[EMC_CTL_CRC];
			short_gap_tx_out       <= ctl_q[EMC_CTL_SGAP] & sg_s_q[1];
			transmit_pacing_enable_out <= ctl_q[EMC_CTL_PACE];
			// hold new transmissions while pause observed
			tx_hold_out            <= tx_pause_q != 16'h0000;
			// half duplex: forced collisions while triggered
			force_collision_out    <= rx_flow_act & ~fd_mode;
			rx_max_len_out         <= maxlen_q;
			tx_gap_out             <= txgap_q;
		end
	end

endmodule

// file: include/emc_pkg.sv
package emc_pkg;

	// ==========================================================
	// register offsets
	localparam logic [11:0] EMC_ADDR_ID       = 12'h000;
	localparam logic [11:0] EMC_ADDR_CONTROL  = 12'h004;
	localparam logic [11:0] EMC_ADDR_STATUS   = 12'h008;
	localparam logic [11:0] EMC_ADDR_SRESET   = 12'h00c;
	localparam logic [11:0] EMC_ADDR_MAXLEN   = 12'h010;
	localparam logic [11:0] EMC_ADDR_RXPAUSE  = 12'h018;
	localparam logic [11:0] EMC_ADDR_TXPAUSE  = 12'h01c;
	localparam logic [11:0] EMC_ADDR_EMUL     = 12'h020;
	localparam logic [11:0] EMC_ADDR_TXGAP    = 12'h028;

	// ==========================================================
	// control word fields
	localparam int EMC_CTL_CMF   = 24;
	localparam int EMC_CTL_CSF   = 23;
	localparam int EMC_CTL_CEF   = 22;
	localparam int EMC_CTL_EXT   = 18;
	localparam int EMC_CTL_GIGF  = 17;
	localparam int EMC_CTL_IFB   = 16;
	localparam int EMC_CTL_IFA   = 15;
	localparam int EMC_CTL_XGEN  = 13;
	localparam int EMC_CTL_CRC   = 12;
	localparam int EMC_CTL_IDLE  = 11;
	localparam int EMC_CTL_SGAP  = 10;
	localparam int EMC_CTL_TEN_GIGABIT_MODE  = 8;
	localparam int EMC_CTL_GIG   = 7;
	localparam int EMC_CTL_PACE  = 6;
	localparam int EMC_CTL_GEN   = 5;
	localparam int EMC_CTL_TXFL  = 4;
	localparam int EMC_CTL_RXFL  = 3;
	localparam int EMC_CTL_LOOP  = 1;
	localparam int EMC_CTL_FD    = 0;
	localparam logic [31:0] EMC_CTL_WMASK = 32'h01c7bdfb;

	// status word fields
	localparam int EMC_ST_IDLE   = 31;
	localparam int EMC_ST_EXTGIG = 4;
	localparam int EMC_ST_EXTFD  = 3;
	localparam int EMC_ST_RXACT  = 1;
	localparam int EMC_ST_TXACT  = 0;

	// ==========================================================
	// reset values
	localparam logic [31:0] EMC_CTL_RESET    = 32'h00000000;
	localparam logic [13:0] EMC_MAXLEN_RESET = 14'h05ee;
	localparam logic [15:0] EMC_TXGAP_RESET  = 16'h000c;
	localparam logic [1:0]  EMC_EMUL_RESET   = 2'h0;
	localparam logic [15:0] EMC_PAUSE_RELOAD = 16'hff00;
	localparam logic [1:0]  EMC_RESP_OKAY    = 2'h0;

	// ==========================================================
	// timing
	localparam int EMC_CLK_NS          = 40;
	localparam int EMC_LINK_TIMEOUT_NS = 1000;
	localparam int EMC_LINK_TIMEOUT_CYC = EMC_LINK_TIMEOUT_NS / EMC_CLK_NS;
	localparam int EMC_SLOT_NS         = 512;
	localparam int EMC_SLOT_CYC = (EMC_SLOT_NS + EMC_CLK_NS - 1) / EMC_CLK_NS;

	// ==========================================================
	// frame carriers
	typedef struct packed {
		logic        valid;
		logic        control;
		logic        pause;
		logic        short_frame;
		logic        crc_err;
		logic        align_err;
		logic        code_err;
		logic [15:0] pause_quanta;
	} emc_rx_frame_t;

	typedef struct packed {
		logic valid;
		logic deliver;
		logic control;
		logic fragment;
		logic undersized;
		logic crc_err;
		logic align_err;
		logic code_err;
	} emc_rx_result_t;

endpackage

// file: verif/emc_control_bank_properties.sv
module emc_control_bank_properties
	import emc_pkg::*;
(
	input wire logic           clk_in,
	input wire logic           reset_in,
	input wire logic           s_axi_awvalid_in,
	input wire logic           s_axi_awready_out,
	input wire logic           s_axi_wvalid_in,
	input wire logic           s_axi_wready_out,
	input wire logic [1:0]     s_axi_bresp_out,
	input wire logic           s_axi_bvalid_out,
	input wire logic           s_axi_bready_in,
	input wire logic           s_axi_arvalid_in,
	input wire logic           s_axi_arready_out,
	input wire logic [31:0]    s_axi_rdata_out,
	input wire logic           s_axi_rvalid_out,
	input wire logic           s_axi_rready_in,
	input wire emc_rx_frame_t  rx_frame_in,
	input wire emc_rx_result_t rx_result_out,
	input wire logic           gig_mode_out,
	input wire logic           full_duplex_mode_out,
	input wire logic           ten_gigabit_mode_out,
	input wire logic           send_pause_out,
	input wire logic           mac_reset_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// sequences
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	sequence s_wr_taken;
		s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
	endsequence
	sequence s_short_frame(bit err);
		rx_frame_in.valid && rx_frame_in.short_frame &&
		((rx_frame_in.crc_err || rx_frame_in.align_err || rx_frame_in.code_err) == err);
	endsequence
	// ==========================================================
	// bus
	wr_answer_a: assert property (s_wr_taken |-> ##2
		(s_axi_bvalid_out && s_axi_bresp_out == EMC_RESP_OKAY))
		else $error("write answer missing");
	b_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
		else $error("bvalid dropped early");
	rd_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
		else $error("read answer missing");
	r_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
		s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data not held");
	// ==========================================================
	// frames and modes
	frag_mark_a: assert property (s_short_frame(1'b1) |=>
		rx_result_out.valid && rx_result_out.fragment && !rx_result_out.undersized)
		else $error("fragment mark wrong");
	under_mark_a: assert property (s_short_frame(1'b0) |=>
		rx_result_out.valid && rx_result_out.undersized && !rx_result_out.fragment)
		else $error("undersized mark wrong");
	result_cause_a: assert property (rx_result_out.valid |-> $past(rx_frame_in.valid))
		else $error("result without frame");
	gig_full_a: assert property (gig_mode_out |-> full_duplex_mode_out)
		else $error("gigabit not full duplex");
	speed_excl_a: assert property (ten_gigabit_mode_out |-> !gig_mode_out)
		else $error("two speeds at once");
	pause_pulse_a: assert property (send_pause_out |=> !send_pause_out [*4])
		else $error("pause frame repeated");
	mac_rst_pulse_a: assert property (mac_reset_out |=> !mac_reset_out)
		else $error("mac reset not a pulse");
endmodule

bind emc_control_bank emc_control_bank_properties i_props (.*);

// file: verif/emc_phy_model.sv
module emc_phy_model (
	input  wire logic run_in,
	output logic      tclk_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// transmit clock
	// stopping it stalls at the last level, as a real phy does
	initial begin
		tclk_out = 1'b0;
		forever begin
			#160;
			if (run_in) begin
				tclk_out = ~tclk_out;
			end
		end
	end
endmodule

// file: verif/emc_control_bank_tb_top.sv
module emc_control_bank_tb_top
	import emc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] ID_V = 32'h5a5a0001; // arbitrary value
	logic clk_in, reset_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
	logic s_axi_arvalid_in, s_axi_rready_in, full_duplex_in, gig_in, short_gap_in;
	logic transmit_clock_input_in, rx_busy_in, tx_busy_in, rx_flow_trigger_in, phy_run;
	logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
	logic s_axi_rvalid_out, gig_out, full_duplex_out, full_duplex_mode_out, gig_mode_out;
	logic ten_gigabit_mode_out, interface_output_a_out, interface_output_b_out;
	logic gig_path_reset_out, ten_gig_path_reset_out, crc_castagnoli_out, short_gap_tx_out;
	logic transmit_pacing_enable_out, tx_hold_out, send_pause_out, force_collision_out;
	logic mac_reset_out, sg, sf, gm;
	logic [11:0] s_axi_awaddr_in, s_axi_araddr_in;
	logic [31:0] s_axi_wdata_in, s_axi_rdata_out, r, v;
	logic [3:0] s_axi_wstrb_in;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
	logic [13:0] rx_max_len_out;
	logic [15:0] tx_gap_out;
	emc_rx_frame_t rx_frame_in, f;
	emc_rx_result_t rx_result_out;
	logic [31:0] rq[$];
	logic [2:0] fq[$];
	int n_errors = 0, cmp_count = 0, seed = 96693, k;

	emc_control_bank #(.ID_VERSION(ID_V)) i_dut (.*);
	emc_phy_model i_phy (.run_in(phy_run), .tclk_out(transmit_clock_input_in));

	// ==========================================================
	// helpers
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected at %0t: got %h want %h", $time, s, e);
		end
	endtask
	task automatic results();
		if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bit ta, tw;
		ta = 0;
		tw = 0;
		@(posedge clk_in);
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= d;
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		while (!(ta && tw)) begin
			@(posedge clk_in);
			if (!ta && s_axi_awready_out === 1'b1) begin
				ta = 1;
				s_axi_awvalid_in <= 1'b0;
			end
			if (!tw && s_axi_wready_out === 1'b1) begin
				tw = 1;
				s_axi_wvalid_in <= 1'b0;
			end
		end
		while (s_axi_bvalid_out !== 1'b1) @(posedge clk_in);
		s_axi_bready_in <= 1'b1;
		do @(posedge clk_in); while (s_axi_bvalid_out !== 1'b1);
		s_axi_bready_in <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		rq.push_back(e);
		@(posedge clk_in);
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'b1;
		do @(posedge clk_in); while (s_axi_arready_out !== 1'b1);
		s_axi_arvalid_in <= 1'b0;
		while (s_axi_rvalid_out !== 1'b1) @(posedge clk_in);
		s_axi_rready_in <= 1'b1;
		do @(posedge clk_in); while (s_axi_rvalid_out !== 1'b1);
		s_axi_rready_in <= 1'b0;
	endtask
	task automatic snd(input emc_rx_frame_t fr, input logic [2:0] e);
		@(posedge clk_in);
		rx_frame_in <= fr;
		fq.push_back(e);
	endtask

	// ==========================================================
	// monitors
	always @(posedge clk_in) begin
		if (s_axi_rvalid_out === 1'b1 && s_axi_rready_in === 1'b1) begin
			chk(s_axi_rdata_out, rq.pop_front());
			chk(32'(s_axi_rresp_out), 32'(EMC_RESP_OKAY));
		end
		if (rx_result_out.valid === 1'b1) chk({29'h0, rx_result_out.deliver, rx_result_out.fragment,
			rx_result_out.undersized}, {29'h0, fq.pop_front()});
	end
	initial begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end
	initial begin
		repeat (6000) @(posedge clk_in);
		n_errors++;
		results();
	end

	// ==========================================================
	// main sequence
	initial begin
		{s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in} = 4'h0;
		{s_axi_rready_in, full_duplex_in, gig_in, short_gap_in, phy_run} = 5'h0;
		{rx_busy_in, tx_busy_in, rx_flow_trigger_in} = 3'h0;
		{s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = '0;
		s_axi_wstrb_in = 4'hf;
		rx_frame_in = '0;
		reset_in = 1'b1;
		repeat (8) @(posedge clk_in);
		reset_in <= 1'b0;
		rd(EMC_ADDR_ID, ID_V);
		rd(EMC_ADDR_CONTROL, 32'h0);
		rd(EMC_ADDR_MAXLEN, 32'h5ee);
		rd(EMC_ADDR_TXGAP, 32'hc);
		chk(32'({rx_max_len_out, tx_gap_out}), {2'h0, EMC_MAXLEN_RESET, EMC_TXGAP_RESET});
		rd(12'h014, 32'h0);
		wr(EMC_ADDR_CONTROL, 32'hffffffff);
		rd(EMC_ADDR_CONTROL, EMC_CTL_WMASK);
		wr(12'h024, 32'hffffffff);
		rd(12'h024, 32'h0);
		wr(EMC_ADDR_MAXLEN, 32'hffffffff);
		wr(EMC_ADDR_TXGAP, 32'h12345678);
		wr(EMC_ADDR_EMUL, 32'hffffffff);
		rd(EMC_ADDR_MAXLEN, 32'h3fff);
		rd(EMC_ADDR_TXGAP, 32'h5678);
		rd(EMC_ADDR_EMUL, 32'h3);
		chk(32'({rx_max_len_out, tx_gap_out}), 32'h3fff5678);
		for (int i = 0; i < 12; i++) begin
			r = $random(seed);
			v = $random(seed) & EMC_CTL_WMASK;
			@(posedge clk_in);
			{short_gap_in, gig_in, full_duplex_in, phy_run} <= r[3:0];
			wr(EMC_ADDR_CONTROL, v);
			repeat (40) @(posedge clk_in);
			sg = v[18] ? r[2] : v[7];
			sf = v[18] ? r[1] : v[0];
			gm = sg && (r[0] || v[17]);
			chk(32'({interface_output_b_out, interface_output_a_out}), 32'(v[16:15]));
			chk(32'({ten_gig_path_reset_out, gig_path_reset_out}), 32'({!v[13], !v[5]}));
			chk(32'({crc_castagnoli_out, transmit_pacing_enable_out, short_gap_tx_out}),
				32'({v[12], v[6], v[10] & r[3]}));
			chk(32'({ten_gigabit_mode_out, gig_mode_out, gig_out}),
				32'({v[8], gm & !v[8], v[7]}));
			chk(32'({full_duplex_mode_out, full_duplex_out}),
				32'({v[1] | gm | sf, v[0]}));
			rd(EMC_ADDR_CONTROL, v);
			rd(EMC_ADDR_STATUS, {v[11], 26'h0, v[18] & r[2], v[18] & r[1], 3'h0});
		end
		for (int m = 0; m < 8; m++) begin
			wr(EMC_ADDR_CONTROL, (32'(m) << 22) | 32'h20);
			for (int i = 0; i < 6; i++) begin
				r = $random(seed);
				f = '0;
				{f.code_err, f.align_err, f.crc_err, f.short_frame, f.control, f.valid} = {r[4:0], 1'b1};
				f.pause_quanta = r[31:16];
				gm = |r[4:2];
				sg = r[1] ? m[1] : gm ? m[0] : r[0] ? m[2] : 1'b1;
				snd(f, {sg, r[1] & gm, r[1] & !gm});
			end
			@(posedge clk_in);
			rx_frame_in <= '0;
		end
		f = '0;
		{f.valid, f.control, f.pause, f.pause_quanta} = {3'h7, 16'h0002};
		for (int i = 0; i < 3; i++) begin
			wr(EMC_ADDR_CONTROL, i == 0 ? 32'h31 : i == 1 ? 32'h21 : 32'h30);
			snd(f, 3'h0);
			@(posedge clk_in);
			rx_frame_in <= '0;
			repeat (3) @(posedge clk_in);
			chk(32'(tx_hold_out), 32'(!i));
			rd(EMC_ADDR_STATUS, 32'(i == 0));
			repeat (40) @(posedge clk_in);
			chk(32'(tx_hold_out), 32'h0);
		end
		wr(EMC_ADDR_CONTROL, 32'h29);
		rx_flow_trigger_in <= 1'b1;
		k = 0;
		repeat (8) @(posedge clk_in) if (send_pause_out === 1'b1) k++;
		chk(32'(k), 32'h1);
		rd(EMC_ADDR_STATUS, 32'h2);
		wr(EMC_ADDR_CONTROL, 32'h28);
		repeat (4) @(posedge clk_in);
		chk(32'(force_collision_out), 32'h1);
		wr(EMC_ADDR_CONTROL, 32'h20);
		repeat (4) @(posedge clk_in);
		chk(32'(force_collision_out), 32'h0);
		rx_flow_trigger_in <= 1'b0;
		rx_busy_in <= 1'b1;
		wr(EMC_ADDR_CONTROL, 32'h820);
		rd(EMC_ADDR_STATUS, 32'h0);
		rx_busy_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		rd(EMC_ADDR_STATUS, 32'h80000000);
		wr(EMC_ADDR_SRESET, 32'h1);
		rd(EMC_ADDR_SRESET, 32'h0);
		rd(EMC_ADDR_CONTROL, 32'h820);
		repeat (4) @(posedge clk_in);
		results();
	end
endmodule
